// >>> common/rsttr_regs.svh
// Constants for the reset supervisor and NAND tree test block.
// What this block does
// - Manual reset low forces reset, stretched output.
// - Drive bidirectional pin low on main supply low.
// - External low on bidirectional pin acts as reset.
// - Output low on manual, bidirectional or second supply.
// - Power-on loads defaults; run after supply good.
// - Power-on initializes all listed control registers.
// - Value and limit registers get no defined contents.
// - Bidirectional pin low resets registers, converter idle.
// - Config bit 4 starts soft reset, self-clears.
// - Soft reset spares test and analog output registers.
// - Latch test-entry pin at power-up; high enters tree mode.
// - Tree mode persists until power is removed.
// - Address pin becomes NAND chain output in tree mode.
// - Tree output reads 1 all-low, inverts each step.
// - Configuration register power-on value is 0010 0101.
// - Trip point lock cleared only by reset output or power-on.
`ifndef RSTTR_REGS_SVH
`define RSTTR_REGS_SVH

`define RSTTR_CFG_ADDR 8'h40
`define RSTTR_CFG_POR 8'h25
`define RSTTR_CFG_LOCK_BIT 3
`define RSTTR_CFG_SOFT_BIT 4
`define RSTTR_CLK_PERIOD_NS 10
`define RSTTR_STRETCH_NS 200000
`define RSTTR_STRETCH_CYCLES (`RSTTR_STRETCH_NS / `RSTTR_CLK_PERIOD_NS)
`define RSTTR_SAMPLE_WAIT 2'h2
`define RSTTR_TREE_INPUTS 4

`endif

// >>> common/rsttr_pkg.sv
// Types shared by the reset supervisor and NAND tree test block.
package rsttr_pkg;

    typedef enum logic [1:0] {
        RSTTR_POWER_SAMPLE = 2'b00,
        RSTTR_HELD = 2'b01,
        RSTTR_RUN = 2'b10
    } rsttr_state_e;

    // Register initialize requests sent to the register file.
    typedef struct packed {
        logic all_regs;   // Test and analog output registers as well.
        logic core_regs;  // Configuration, status, mirror, mask, trip points.
    } rsttr_init_s;

    // Chain inputs, index 0 farthest from the tree output.
    typedef struct packed {
        logic manual;
        logic sda;
        logic scl;
        logic general;
    } rsttr_chain_s;

    typedef logic [15:0] rsttr_count_t;

endpackage

// >>> design/rsttr_stretch.sv
// Reset stretcher: holds its output for a fixed count after the request ends.
module rsttr_stretch #(
    parameter rsttr_pkg::rsttr_count_t STRETCH = 16'h4E20
) (
    input wire logic clk,          // Device clock.
    input wire logic rst_n,        // Power-on reset, active low.
    input wire logic hold,         // Reset request level.
    output logic stretched         // Stretched reset, active high.
);
    rsttr_pkg::rsttr_count_t count_reg;
    rsttr_pkg::rsttr_count_t count_next;
    logic stretched_next;

    // Starts asserted and fully loaded so power-up also gets the full stretch.
    assign count_next = hold ? STRETCH :
                        (count_reg != 16'h0000) ? count_reg - 16'h0001 : count_reg;
    assign stretched_next = hold | (count_reg > 16'h0001);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= STRETCH;
            stretched <= 1'b1;
        end else begin
            count_reg <= count_next;
            stretched <= stretched_next;
        end
    end
endmodule

// >>> design/rsttr_top.sv
// Reset supervisor, soft reset, configuration lock and NAND tree test logic.
`include "rsttr_regs.svh"

module rsttr_top #(
    parameter rsttr_pkg::rsttr_count_t STRETCH_CYCLES = 16'(`RSTTR_STRETCH_CYCLES)
) (
    input wire logic MCLK,                           // Device clock, 100 MHz.
    input wire logic RST_N,                          // Power-on reset, active low.
    input wire logic MANUAL_RESET_IN_N,              // Manual reset pin, active low.
    input wire logic BIDIR_RESET_N_LEVEL,            // Bidirectional reset pin level.
    output logic BIDIR_RESET_N_DRIVE,                // Bidirectional reset drive value.
    output logic BIDIR_RESET_N_OE_N,                 // Low while driving the pin.
    input wire logic MAIN_SUPPLY_LOW,                // Main supply below reset threshold.
    input wire logic SECOND_SUPPLY_MONITOR_LOW,      // Second supply below threshold.
    input wire logic FAN_LEVEL_TEST_ENTRY_PIN,       // Test entry strap pin.
    input wire logic GENERAL_LOGIC_INPUT,            // General input pin.
    input wire logic SCL,                            // Serial clock pin level.
    input wire logic SDA,                            // Serial data pin level.
    input wire logic REG_WR,                         // Register write strobe.
    input wire logic [7:0] REG_ADDR,                 // Register write address.
    input wire logic [7:0] REG_WDATA,                // Register write data.
    output logic STRETCHED_RESET_OUT_N,              // Stretched reset output.
    output logic ADDRESS_SELECT_TREE_OUT,            // Tree output drive value.
    output logic ADDRESS_SELECT_TREE_OUT_OE_N,       // Low while driving tree out.
    output logic [7:0] CONFIG_REG,                   // Configuration register.
    output logic TRIP_LOCK,                          // Trip point lock.
    output rsttr_pkg::rsttr_init_s REG_INIT,         // Register initialize levels.
    output logic CONVERTER_IDLE,                     // Converter sequencing held.
    output logic NAND_TREE_MODE                      // Tree test mode latched.
);
    // Every supply, reset, strap and chain pin passes two flops; only stage two is read by logic.
    localparam int NSYNC = 8;
    logic [NSYNC-1:0] pin_async;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    // Idle levels for reset: resets and supply flags inactive, strap and chain pins (general, SCL, SDA) low.
    localparam logic [NSYNC-1:0] SYNC_IDLE = 8'h03;

    assign pin_async = {SDA, SCL, GENERAL_LOGIC_INPUT, FAN_LEVEL_TEST_ENTRY_PIN,
                        SECOND_SUPPLY_MONITOR_LOW, MAIN_SUPPLY_LOW,
                        BIDIR_RESET_N_LEVEL, MANUAL_RESET_IN_N};

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            sync1_reg <= SYNC_IDLE;
            sync2_reg <= SYNC_IDLE;
        end else begin
            sync1_reg <= pin_async;
            sync2_reg <= sync1_reg;
        end
    end

    wire manual_n_s = sync2_reg[0];
    wire bidir_n_s = sync2_reg[1];
    wire main_low_s = sync2_reg[2];
    wire second_low_s = sync2_reg[3];
    wire strap_s = sync2_reg[4];

    // One assignment for the whole struct keeps the chain variable single-driven.
    rsttr_pkg::rsttr_chain_s chain;
    assign chain = {manual_n_s, sync2_reg[7], sync2_reg[6], sync2_reg[5]};

    // Power-up sequencing.
    rsttr_pkg::rsttr_state_e state_reg;
    rsttr_pkg::rsttr_state_e state_next;
    logic [1:0] wait_reg;
    logic nand_mode_reg;
    wire in_power_sample = (state_reg == rsttr_pkg::RSTTR_POWER_SAMPLE);
    wire sample_done = in_power_sample & (wait_reg == `RSTTR_SAMPLE_WAIT);
    wire pin_reset = ~manual_n_s | ~bidir_n_s;
    wire supply_bad = main_low_s;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rsttr_pkg::RSTTR_POWER_SAMPLE: begin
                if (sample_done) begin
                    state_next = rsttr_pkg::RSTTR_HELD;
                end
            end
            rsttr_pkg::RSTTR_HELD: begin
                if (!supply_bad && !pin_reset) begin
                    state_next = rsttr_pkg::RSTTR_RUN;
                end
            end
            rsttr_pkg::RSTTR_RUN: begin
                if (supply_bad || pin_reset) begin
                    state_next = rsttr_pkg::RSTTR_HELD;
                end
            end
            default: begin
                state_next = rsttr_pkg::RSTTR_POWER_SAMPLE;
            end
        endcase
    end

    // The strap is caught after reset release, once the synchroniser has filled.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            state_reg <= rsttr_pkg::RSTTR_POWER_SAMPLE;
            wait_reg <= 2'h0;
            nand_mode_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (in_power_sample && !sample_done) begin
                wait_reg <= wait_reg + 2'h1;
            end
            if (sample_done) begin
                nand_mode_reg <= strap_s;
            end
        end
    end

    // Bidirectional pin: pulled low by us on main supply fault.
    logic bidir_oe_n_reg;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            bidir_oe_n_reg <= 1'b0;
        end else begin
            bidir_oe_n_reg <= ~main_low_s;
        end
    end
    assign BIDIR_RESET_N_DRIVE = 1'b0;
    assign BIDIR_RESET_N_OE_N = bidir_oe_n_reg;

    // Stretched reset output; held from power-on until the stretch ends.
    wire stretch_hold = pin_reset | second_low_s | main_low_s | in_power_sample;
    logic stretched;
    rsttr_stretch #(
        .STRETCH(STRETCH_CYCLES)
    ) u_stretch (
        .clk(MCLK),
        .rst_n(RST_N),
        .hold(stretch_hold),
        .stretched(stretched)
    );
    assign STRETCHED_RESET_OUT_N = ~stretched;

    // Configuration register with soft reset and write-once lock.
    logic [7:0] cfg_reg;
    logic [7:0] cfg_next;
    logic init_all_reg;
    logic init_core_reg;
    wire hard_init = (state_reg != rsttr_pkg::RSTTR_RUN);
    wire soft_req = cfg_reg[`RSTTR_CFG_SOFT_BIT];
    wire cfg_wr = REG_WR & ~hard_init & ~soft_req & (REG_ADDR == `RSTTR_CFG_ADDR);
    wire lock_clear = stretched;
    wire lock_keep = cfg_reg[`RSTTR_CFG_LOCK_BIT] & ~lock_clear;
    wire lock_set = cfg_wr & REG_WDATA[`RSTTR_CFG_LOCK_BIT];

    // The lock bit only goes to one by a write; soft reset leaves it alone.
    always_comb begin
        cfg_next = cfg_reg;
        if (hard_init || soft_req) begin
            cfg_next = `RSTTR_CFG_POR;
        end else if (cfg_wr) begin
            cfg_next = REG_WDATA;
        end
        cfg_next[`RSTTR_CFG_LOCK_BIT] = lock_keep | lock_set;
    end

    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_reg <= `RSTTR_CFG_POR;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // Value and limit registers are not in either init set.
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            init_all_reg <= 1'b1;
            init_core_reg <= 1'b1;
        end else begin
            init_all_reg <= hard_init;
            init_core_reg <= hard_init | soft_req;
        end
    end

    // NAND chain: general input farthest, manual reset nearest the output.
    localparam int NT = `RSTTR_TREE_INPUTS;
    logic [NT-1:0] chain_in;
    logic [NT:0] stage;
    assign chain_in = chain;
    assign stage[0] = 1'b1;
    genvar gi;
    generate
        for (gi = 0; gi < NT; gi = gi + 1) begin : g_nand
            assign stage[gi+1] = ~(chain_in[gi] & stage[gi]);
        end
    endgenerate

    logic tree_out_reg;
    logic tree_oe_n_reg;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            tree_out_reg <= 1'b1;
            tree_oe_n_reg <= 1'b1;
        end else begin
            tree_out_reg <= stage[NT];
            tree_oe_n_reg <= ~nand_mode_reg;
        end
    end

    logic idle_reg;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            idle_reg <= 1'b1;
        end else begin
            idle_reg <= hard_init;
        end
    end

    assign ADDRESS_SELECT_TREE_OUT = tree_out_reg;
    assign ADDRESS_SELECT_TREE_OUT_OE_N = tree_oe_n_reg;
    assign CONFIG_REG = cfg_reg;
    assign TRIP_LOCK = cfg_reg[`RSTTR_CFG_LOCK_BIT];
    assign REG_INIT = {init_all_reg, init_core_reg};
    assign CONVERTER_IDLE = idle_reg;
    assign NAND_TREE_MODE = nand_mode_reg;
endmodule

// >>> testbench/rsttr_top_assertions.sv
// Concurrent checks on the ports of the reset supervisor top level.
module rsttr_top_assertions #(
    parameter rsttr_pkg::rsttr_count_t STRETCH_CYCLES = 16'h0010
) (
    input wire logic MCLK, // Device clock.
    input wire logic RST_N, // Power-on reset, active low.
    input wire logic MANUAL_RESET_IN_N, // Manual reset pin.
    input wire logic BIDIR_RESET_N_LEVEL, // Reset wire level.
    input wire logic BIDIR_RESET_N_DRIVE, // Reset wire drive value.
    input wire logic BIDIR_RESET_N_OE_N, // Low while driving the wire.
    input wire logic MAIN_SUPPLY_LOW, // Main supply fault.
    input wire logic SECOND_SUPPLY_MONITOR_LOW, // Second supply fault.
    input wire logic FAN_LEVEL_TEST_ENTRY_PIN, // Test entry strap.
    input wire logic GENERAL_LOGIC_INPUT, // Chain input, farthest.
    input wire logic SCL, // Chain input.
    input wire logic SDA, // Chain input.
    input wire logic REG_WR, // Write strobe.
    input wire logic [7:0] REG_ADDR, // Write address.
    input wire logic [7:0] REG_WDATA, // Write data.
    input wire logic STRETCHED_RESET_OUT_N, // Stretched reset output.
    input wire logic ADDRESS_SELECT_TREE_OUT, // Tree output.
    input wire logic ADDRESS_SELECT_TREE_OUT_OE_N, // Low while driving the tree output.
    input wire logic [7:0] CONFIG_REG, // Configuration register.
    input wire logic TRIP_LOCK, // Trip point lock.
    input wire rsttr_pkg::rsttr_init_s REG_INIT, // Register initialize levels.
    input wire logic CONVERTER_IDLE, // Converter held idle.
    input wire logic NAND_TREE_MODE // Tree mode latched.
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    logic [15:0] good_cnt_reg;
    logic [15:0] good_cnt_next;
    wire all_good = MANUAL_RESET_IN_N && BIDIR_RESET_N_LEVEL && !MAIN_SUPPLY_LOW && !SECOND_SUPPLY_MONITOR_LOW;
    wire [3:0] chain = {MANUAL_RESET_IN_N, SDA, SCL, GENERAL_LOGIC_INPUT};
    wire t2 = ~(SCL & ~GENERAL_LOGIC_INPUT);
    wire t1 = ~(SDA & t2);
    wire tree_exp = ~(MANUAL_RESET_IN_N & t1);
    // Saturate so a long quiet spell never wraps back into the legal window.
    assign good_cnt_next = !all_good ? 16'h0000 : (&good_cnt_reg ? good_cnt_reg : good_cnt_reg + 16'h0001);
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) good_cnt_reg <= 16'h0000;
        else good_cnt_reg <= good_cnt_next;
    end
    sequence s_chain_settled;
        (NAND_TREE_MODE && $stable(chain)) [*4];
    endsequence
    sequence s_soft_start;
        $rose(CONFIG_REG[4]);
    endsequence
    a_manual_holds_out: assert property (!MANUAL_RESET_IN_N [*4] |-> !STRETCHED_RESET_OUT_N)
        else $error("manual reset did not pull the output low");
    a_supply_drives_pin: assert property (MAIN_SUPPLY_LOW [*4] |-> !BIDIR_RESET_N_OE_N && !BIDIR_RESET_N_DRIVE)
        else $error("low main supply did not drive the reset pin low");
    a_second_supply_out: assert property (SECOND_SUPPLY_MONITOR_LOW [*4] |-> !STRETCHED_RESET_OUT_N)
        else $error("low second supply did not pull the output low");
    a_pin_in_resets: assert property (!BIDIR_RESET_N_LEVEL [*6] |-> CONVERTER_IDLE && REG_INIT.core_regs)
        else $error("low reset pin did not hold registers and converter");
    a_stretch_length: assert property ($rose(STRETCHED_RESET_OUT_N) |->
        good_cnt_reg >= STRETCH_CYCLES - 2 && good_cnt_reg <= STRETCH_CYCLES + 8)
        else $error("reset output released outside the stretch window");
    a_soft_reset_once: assert property (s_soft_start |=>
        (CONFIG_REG & 8'hF7) == 8'h25 && REG_INIT.core_regs && !REG_INIT.all_regs)
        else $error("soft reset did not self clear and reload core registers");
    a_lock_clear_cause: assert property ($fell(TRIP_LOCK) |-> !STRETCHED_RESET_OUT_N || !$past(STRETCHED_RESET_OUT_N))
        else $error("trip lock cleared without reset output");
    a_tree_mode_sticks: assert property (NAND_TREE_MODE |=> NAND_TREE_MODE)
        else $error("tree test mode was left");
    a_tree_chain_out: assert property (s_chain_settled |->
        !ADDRESS_SELECT_TREE_OUT_OE_N && ADDRESS_SELECT_TREE_OUT == tree_exp)
        else $error("tree output does not match the chain");
endmodule

bind rsttr_top rsttr_top_assertions #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_rsttr_top_assertions (.*);

// >>> testbench/rsttr_partner.sv
// Reset network model: the pulled-up reset wire and an outside pull-down.
module rsttr_partner (
    input wire logic oe_n,     // Device enable, low while driving.
    input wire logic drive,    // Device drive value.
    input wire logic ext_low,  // Network pulls the wire low.
    output logic level         // Resolved wire level.
);
    timeunit 1ns;
    timeprecision 1ns;
    // The wire has a pull-up, so it reads high whenever nobody pulls it down.
    assign level = ((!oe_n && !drive) || ext_low) ? 1'b0 : 1'b1;
endmodule

// >>> testbench/rsttr_top_test.sv
// Self-checking bench for the reset supervisor and tree test block.
module rsttr_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int ST = 16;
    `define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin errors++; \
        $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
    logic mclk = 0, rst_n = 0, man_n = 1, ext_low = 0, sup_low = 0, sec_low = 0, strap = 0;
    logic gen_in = 0, scl = 1, sda = 1, wr = 0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    wire bid_i, bid_o, bid_oe_n, out_n, tree_o, tree_oe_n, lock, conv_idle, tree_mode;
    wire [7:0] cfg;
    wire rsttr_pkg::rsttr_init_s init;
    int errors = 0, n_tests = 0, cyc = 0;
    always #5 mclk = ~mclk;
    rsttr_top #(.STRETCH_CYCLES(16'h0010)) u_rsttr_top (.MCLK(mclk), .RST_N(rst_n), .MANUAL_RESET_IN_N(man_n),
        .BIDIR_RESET_N_LEVEL(bid_i), .BIDIR_RESET_N_DRIVE(bid_o), .BIDIR_RESET_N_OE_N(bid_oe_n),
        .MAIN_SUPPLY_LOW(sup_low), .SECOND_SUPPLY_MONITOR_LOW(sec_low), .FAN_LEVEL_TEST_ENTRY_PIN(strap),
        .GENERAL_LOGIC_INPUT(gen_in), .SCL(scl), .SDA(sda), .REG_WR(wr), .REG_ADDR(addr), .REG_WDATA(wdata),
        .STRETCHED_RESET_OUT_N(out_n),
        .ADDRESS_SELECT_TREE_OUT(tree_o), .ADDRESS_SELECT_TREE_OUT_OE_N(tree_oe_n), .CONFIG_REG(cfg),
        .TRIP_LOCK(lock), .REG_INIT(init), .CONVERTER_IDLE(conv_idle), .NAND_TREE_MODE(tree_mode));
    rsttr_partner u_rsttr_partner (.oe_n(bid_oe_n), .drive(bid_o), .ext_low(ext_low), .level(bid_i));
    task automatic test_done;
        $display("checks %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            test_done;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // Bounded, so a stuck output shows up as a count of 400 instead of a hang.
    task automatic wait_high(output int n);
        n = 0;
        while (out_n !== 1'b1 && n < 400) begin
            tick(1);
            n++;
        end
    endtask
    task automatic power_up(input logic s);
        int n;
        rst_n = 0;
        strap = s;
        tick(5);
        `CHK("cfg por", 8'h25, cfg);
        `CHK("init por", 2'b11, init);
        rst_n = 1;
        tick(10);
        strap = 0;
        wait_high(n);
        `CHK("por stretch", 1'b1, n + 10 >= ST - 1 && n + 10 <= ST + 6);
        tick(2);
        `CHK("run init", 3'b000, {conv_idle, init});
        `CHK("tree mode", s, tree_mode);
    endtask
    task automatic wr_cfg(input logic [7:0] a, input logic [7:0] d);
        wr = 1;
        addr = a;
        wdata = d;
        tick(1);
        wr = 0;
        tick(1);
    endtask
    task automatic soft_lock;
        wr_cfg(8'h40, 8'h08);
        `CHK("lock set", 1'b1, lock);
        wr_cfg(8'h41, 8'hFF);
        `CHK("other addr", 8'h08, cfg);
        wr_cfg(8'h40, 8'h00);
        `CHK("lock kept", 8'h08, cfg);
        // Soft reset bit stands for one cycle only, so it is looked at right after the write edge.
        wr = 1;
        addr = 8'h40;
        wdata = 8'h10;
        tick(1);
        wr = 0;
        `CHK("soft bit", 8'h18, cfg);
        tick(1);
        `CHK("soft cfg", 8'h2D, cfg);
        `CHK("soft init", 2'h1, init);
        tick(1);
        `CHK("soft done", 2'h0, init);
    endtask
    task automatic pulse(input int sel);
        int n;
        man_n = (sel != 0);
        ext_low = (sel == 1);
        sec_low = (sel == 2);
        tick(8);
        `CHK("out low", 1'b0, out_n);
        if (sel == 1) `CHK("held", 2'b11, {conv_idle, init.core_regs});
        `CHK("lock clear", 1'b0, lock);
        man_n = 1;
        ext_low = 0;
        sec_low = 0;
        wait_high(n);
        `CHK("stretch", 1'b1, n >= ST - 1 && n <= ST + 6);
    endtask
    task automatic supply_dip;
        int n;
        sup_low = 1;
        tick(5);
        `CHK("pin drive", 2'b00, {bid_oe_n, bid_i});
        `CHK("dip out", 1'b0, out_n);
        sup_low = 0;
        wait_high(n);
        `CHK("pin free", 1'b1, bid_i);
        `CHK("dip stretch", 1'b1, n >= ST && n <= ST + 8);
    endtask
    // Ones added one at a time from the input nearest the tree output, 500 ns per step.
    task automatic tree_walk;
        logic [3:0] v;
        v = 4'h0;
        for (int i = 0; i < 5; i++) begin
            if (i > 0) v[4 - i] = 1'b1;
            {man_n, sda, scl, gen_in} = v;
            tick(50);
            `CHK("tree out", ~i[0], tree_o);
            `CHK("tree drive", 1'b0, tree_oe_n);
        end
    endtask
    initial begin
        power_up(1'b0);
        `CHK("tree idle", 1'b1, tree_oe_n);
        soft_lock;
        pulse(0);
        pulse(1);
        pulse(2);
        supply_dip;
        power_up(1'b1);
        tree_walk;
        pulse(0);
        `CHK("tree kept", 1'b1, tree_mode);
        test_done;
    end
endmodule
